// ### shared/scss_params.svh
`ifndef SCSS_PARAMS_SVH
`define SCSS_PARAMS_SVH

// Register byte offsets
`define SCSS_SYSCTL_ADDR 8'h00
`define SCSS_FRCCTL_ADDR 8'h04
`define SCSS_FXTCTL_ADDR 8'h08
`define SCSS_SXTCTL_ADDR 8'h0C
`define SCSS_STATUS_ADDR 8'h10
`define SCSS_SUBFREQ_ADDR 8'h14

// System clock control fields
`define SCSS_DIV_MSB 7
`define SCSS_DIV_LSB 5
`define SCSS_FAST_SEL_BIT 3
`define SCSS_LOW_SEL_BIT 2
`define SCSS_FAST_IDLE_BIT 1
`define SCSS_SUB_IDLE_BIT 0
`define SCSS_DIV_SUB_CODE 3'h7

// Oscillator control fields
`define SCSS_FRC_FREQ_MSB 3
`define SCSS_FRC_FREQ_LSB 2
`define SCSS_RUN_FLAG_BIT 1
`define SCSS_ENABLE_BIT 0
`define SCSS_PIN_MUX_BIT 2

// Reset values
`define SCSS_SYSCTL_RST 8'h00
`define SCSS_FRCCTL_RST 4'h1
`define SCSS_FXTCTL_RST 1'h0
`define SCSS_SXTCTL_RST 2'h0

// Slow crystal start-up, in crystal periods
`define SCSS_LXT_START_TICKS 10'h3FF

// Nominal frequencies in Hz
`define SCSS_LXT_HZ 32'h0000_8000
`define SCSS_SLOW_RC_OSC_HZ 32'h0000_7D00
`define SCSS_FRC_8M_HZ 32'h007A_1200
`define SCSS_FRC_12M_HZ 32'h00B7_1B00
`define SCSS_FRC_16M_HZ 32'h00F4_2400

`endif

// ### shared/scss_pkg.sv
package scss_pkg;

  // Clock path selection, changed only on a safe boundary
  typedef struct packed {
    logic [2:0] div_sel;
    logic fast_sel;
    logic low_sel;
  } scss_sel_s;

  // Latched AHB address phase
  typedef struct packed {
    logic [7:0] addr;
    logic write;
  } scss_ap_s;

  typedef enum logic {
    SW_RUN,
    SW_WAIT
  } scss_sw_e;

endpackage

// ### rtl/scss_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "scss_params.svh"

module scss_top (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Oscillator levels
  input wire logic fast_crystal_osc,
  input wire logic fast_rc_osc,
  input wire logic slow_crystal_osc,
  input wire logic slow_rc_osc,
  // Power mode request
  input wire logic cpu_halt,
  // Clock outputs
  output logic sysclk_out,
  output logic sub_clk_out,
  // Oscillator controls
  output logic fast_rc_run,
  output logic [1:0] fast_rc_freq_sel,
  output logic fast_xtal_run,
  output logic slow_xtal_run,
  output logic slow_xtal_pins_osc
);

  // Level of the fast source named by sel
  function automatic logic fast_of(input logic sel, input logic xt, input logic rc);
    fast_of = sel ? xt : rc;
  endfunction

  // Level at the system clock mux for one selection
  function automatic logic path_lvl(input scss_pkg::scss_sel_s s, input logic fast,
                                    input logic sub, input logic [5:0] cnt);
    logic [6:0] taps;
    taps = {cnt, fast};
    if (s.div_sel == `SCSS_DIV_SUB_CODE)
      path_lvl = sub;
    else
      path_lvl = taps[s.div_sel];
  endfunction

  // Software registers
  logic [7:0] sysctl_q;
  logic [3:0] frcctl_q;
  logic fxt_en_q;
  logic [1:0] sxtctl_q;
  scss_pkg::scss_ap_s ap_q;
  logic wr_pend_q;
  logic [31:0] hrdata_q;

  // Clock path state
  scss_pkg::scss_sel_s sel_q;
  scss_pkg::scss_sw_e sw_q;
  logic [5:0] div_cnt_q;
  logic fast_prev_q;
  logic gate_q;
  logic sub_gate_q;
  logic sysclk_q;
  logic sub_clk_q;
  logic [9:0] lxt_cnt_q;
  logic lxt_ready_q;
  logic lxt_prev_q;
  logic fast_rc_run_q;
  logic fast_xt_run_q;
  logic slow_xt_run_q;
  logic pins_osc_q;

  // Bus decode
  wire ap_valid = hsel && hready && htrans[1];
  wire [7:0] ap_addr = {haddr[7:2], 2'h0};
  wire wr_sysctl = wr_pend_q && (ap_q.addr == `SCSS_SYSCTL_ADDR);
  wire wr_frcctl = wr_pend_q && (ap_q.addr == `SCSS_FRCCTL_ADDR);
  wire wr_fxtctl = wr_pend_q && (ap_q.addr == `SCSS_FXTCTL_ADDR);
  wire wr_sxtctl = wr_pend_q && (ap_q.addr == `SCSS_SXTCTL_ADDR);

  // Target selection from software
  scss_pkg::scss_sel_s tgt_sel;
  assign tgt_sel.div_sel = sysctl_q[`SCSS_DIV_MSB:`SCSS_DIV_LSB];
  assign tgt_sel.fast_sel = sysctl_q[`SCSS_FAST_SEL_BIT];
  assign tgt_sel.low_sel = sysctl_q[`SCSS_LOW_SEL_BIT];
  wire fast_idle_en = sysctl_q[`SCSS_FAST_IDLE_BIT];
  wire sub_idle_en = sysctl_q[`SCSS_SUB_IDLE_BIT];
  wire lxt_en = sxtctl_q[`SCSS_ENABLE_BIT];
  wire pin_mux = sxtctl_q[1];

  // Source levels; slow crystal counts as silent until started
  wire lxt_lvl = lxt_ready_q && slow_crystal_osc;
  wire cur_fast = fast_of(sel_q.fast_sel, fast_crystal_osc, fast_rc_osc);
  wire new_fast = fast_of(tgt_sel.fast_sel, fast_crystal_osc, fast_rc_osc);
  wire cur_sub = sel_q.low_sel ? lxt_lvl : slow_rc_osc;
  wire new_sub = tgt_sel.low_sel ? lxt_lvl : slow_rc_osc;
  wire cur_lvl = path_lvl(sel_q, cur_fast, cur_sub, div_cnt_q);
  wire new_lvl = path_lvl(tgt_sel, new_fast, new_sub, div_cnt_q);
  wire fast_tick = cur_fast && !fast_prev_q;
  wire lxt_tick = slow_crystal_osc && !lxt_prev_q;

  // Both sides low means no pulse is cut short
  wire sw_go = (sw_q == scss_pkg::SW_WAIT) && !cur_lvl && !new_lvl;
  wire on_sub = sel_q.div_sel == `SCSS_DIV_SUB_CODE;
  wire fast_keep = sel_q.fast_sel ? fxt_en_q : frcctl_q[`SCSS_ENABLE_BIT];
  wire fast_need = cpu_halt ? fast_idle_en : (!on_sub || fast_keep);
  wire lxt_start_done = lxt_cnt_q == `SCSS_LXT_START_TICKS;

  // Read mux
  logic [31:0] rd_data;
  logic [31:0] sub_hz;
  assign sub_hz = sel_q.low_sel ? `SCSS_LXT_HZ : `SCSS_SLOW_RC_OSC_HZ;
  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (ap_addr)
      `SCSS_SYSCTL_ADDR: rd_data = {24'h00_0000, sysctl_q};
      `SCSS_FRCCTL_ADDR: rd_data = {28'h000_0000, frcctl_q[3:2], fast_rc_run_q, frcctl_q[0]};
      `SCSS_FXTCTL_ADDR: rd_data = {30'h0000_0000, fast_xt_run_q, fxt_en_q};
      `SCSS_SXTCTL_ADDR: rd_data = {29'h0000_0000, pin_mux, lxt_ready_q, lxt_en};
      `SCSS_STATUS_ADDR: rd_data = {25'h000_0000, !gate_q, sw_q == scss_pkg::SW_WAIT, sel_q};
      `SCSS_SUBFREQ_ADDR: rd_data = sub_hz;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Next state of the switch machine
  scss_pkg::scss_sw_e sw_d;
  always_comb
  begin
    case (sw_q)
      scss_pkg::SW_RUN: sw_d = (tgt_sel != sel_q) ? scss_pkg::SW_WAIT : scss_pkg::SW_RUN;
      scss_pkg::SW_WAIT: sw_d = sw_go ? scss_pkg::SW_RUN : scss_pkg::SW_WAIT;
      default: sw_d = scss_pkg::SW_RUN;
    endcase
  end

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ap_q <= '0;
      wr_pend_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      wr_pend_q <= ap_valid && hwrite;
      if (ap_valid)
        ap_q <= '{addr: ap_addr, write: hwrite};
      if (ap_valid && !hwrite)
        hrdata_q <= rd_data;
    end
  end

  // Software registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sysctl_q <= `SCSS_SYSCTL_RST;
      frcctl_q <= `SCSS_FRCCTL_RST;
      fxt_en_q <= `SCSS_FXTCTL_RST;
      sxtctl_q <= `SCSS_SXTCTL_RST;
    end
    else if (clk_en)
    begin
      if (wr_sysctl)
        sysctl_q <= {hwdata[7:5], 1'b0, hwdata[3:0]};
      if (wr_frcctl)
        frcctl_q <= {hwdata[3:2], 1'b0, hwdata[0]};
      if (wr_fxtctl)
        fxt_en_q <= hwdata[`SCSS_ENABLE_BIT];
      if (wr_sxtctl)
        sxtctl_q <= {hwdata[`SCSS_PIN_MUX_BIT], hwdata[`SCSS_ENABLE_BIT]};
    end
  end

  // Divider counts rising edges of the live fast source
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt_q <= 6'h00;
      fast_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      fast_prev_q <= cur_fast;
      if (fast_tick)
        div_cnt_q <= div_cnt_q + 6'h01;
    end
  end

  // Glitch-free selection and gating
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_q <= '0;
      sw_q <= scss_pkg::SW_RUN;
      gate_q <= 1'b1;
      sub_gate_q <= 1'b1;
      sysclk_q <= 1'b0;
      sub_clk_q <= 1'b0;
    end
    else if (clk_en)
    begin
      sw_q <= sw_d;
      if (sw_go)
        sel_q <= tgt_sel;
      if (!cur_lvl)
        gate_q <= !cpu_halt;
      if (!cur_sub)
        sub_gate_q <= !cpu_halt || sub_idle_en;
      sysclk_q <= cur_lvl && gate_q && !sw_go;
      sub_clk_q <= cur_sub && sub_gate_q;
    end
  end

  // Slow crystal start-up; counts crystal periods, not ref_clk
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lxt_cnt_q <= 10'h000;
      lxt_ready_q <= 1'b0;
      lxt_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      lxt_prev_q <= slow_crystal_osc;
      if (!slow_xt_run_q)
      begin
        lxt_cnt_q <= 10'h000;
        lxt_ready_q <= 1'b0;
      end
      else if (lxt_tick && !lxt_start_done)
        lxt_cnt_q <= lxt_cnt_q + 10'h001;
      else if (lxt_start_done)
        lxt_ready_q <= 1'b1;
    end
  end

  // Oscillator enables; fast one held while its path is live
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fast_rc_run_q <= 1'b1;
      fast_xt_run_q <= 1'b0;
      slow_xt_run_q <= 1'b0;
      pins_osc_q <= 1'b0;
    end
    else if (clk_en)
    begin
      fast_rc_run_q <= !sel_q.fast_sel && fast_need;
      fast_xt_run_q <= sel_q.fast_sel && fast_need;
      slow_xt_run_q <= lxt_en && pin_mux;
      pins_osc_q <= pin_mux;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign sysclk_out = sysclk_q;
  assign sub_clk_out = sub_clk_q;
  assign fast_rc_run = fast_rc_run_q;
  assign fast_rc_freq_sel = frcctl_q[`SCSS_FRC_FREQ_MSB:`SCSS_FRC_FREQ_LSB];
  assign fast_xtal_run = fast_xt_run_q;
  assign slow_xtal_run = slow_xt_run_q;
  assign slow_xtal_pins_osc = pins_osc_q;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !clk_en);

  sequence s_switch_now;
    sw_go;
  endsequence

  AST_SWITCH_SAFE: assert property (s_switch_now |=> !sysclk_q && sel_q == $past(tgt_sel))
    else $error("selection changed with clock high");

  AST_NO_EARLY_SWITCH: assert property ((sw_q == scss_pkg::SW_WAIT && cur_lvl) |=> $stable(sel_q))
    else $error("selection moved while output path was high");

  AST_DIV_COUNT: assert property (fast_tick |=> div_cnt_q == $past(div_cnt_q) + 6'h01)
    else $error("divider missed a fast edge");

  AST_FAST_PASS: assert property ((sel_q.div_sel == 3'h0 && gate_q && !sw_go
                                   && sw_q == scss_pkg::SW_RUN) |=> sysclk_q == $past(cur_fast))
    else $error("undivided fast clock not passed");

  AST_SUB_PASS: assert property ((on_sub && gate_q && sw_q == scss_pkg::SW_RUN)
                                 |=> sysclk_q == $past(cur_sub))
    else $error("sub clock not passed");

  AST_HALT_GATE: assert property ((cpu_halt && !gate_q) [*2] |-> !sysclk_q)
    else $error("system clock running while halted");

  AST_LXT_WAIT: assert property ($rose(lxt_ready_q) |-> $past(slow_xt_run_q)
                                 && $past(lxt_cnt_q) == `SCSS_LXT_START_TICKS)
    else $error("slow crystal ready before start-up");

  AST_LXT_SILENT: assert property ((sel_q.low_sel && !lxt_ready_q) |-> !cur_sub)
    else $error("unstarted slow crystal reached sub clock");

  AST_FAST_STOP: assert property ((!cpu_halt && on_sub && !sel_q.fast_sel
                                   && !frcctl_q[0]) |=> !fast_rc_run_q)
    else $error("fast oscillator kept despite disable");

  AST_PIN_OWNER: assert property (slow_xt_run_q |-> pins_osc_q)
    else $error("slow crystal running without its pins");

endmodule

`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "scss_params.svh"

module tb;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
  } scss_row_s;

  logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, hsel = 1'b1, hwrite = 1'b0;
  logic cpu_halt = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic [1:0] htrans = 2'h0, fast_rc_freq_sel;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, sysclk_out, sub_clk_out, fast_rc_run, fast_xtal_run;
  logic slow_xtal_run, slow_xtal_pins_osc;
  logic fast_crystal_osc = 1'b0, fast_rc_osc = 1'b0;
  logic slow_crystal_osc = 1'b0, slow_rc_osc = 1'b0;
  logic [3:0] cyc = 4'h0, sx = 4'h0;
  int n_errors = 0, n_compared = 0;

  // Read rows first: reset values; read-only status bits masked out
  scss_row_s rows [13] = '{
    '{1'b0, 8'h00, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000},
    '{1'b0, 8'h04, 32'h0000_0000, 32'hFFFF_FFFD, 32'h0000_0001},
    '{1'b0, 8'h08, 32'h0000_0000, 32'hFFFF_FFFD, 32'h0000_0000},
    '{1'b0, 8'h0C, 32'h0000_0000, 32'hFFFF_FFFD, 32'h0000_0000},
    '{1'b1, 8'h00, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_00EF},
    '{1'b1, 8'h00, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000},
    '{1'b1, 8'h04, 32'h0000_000D, 32'hFFFF_FFFD, 32'h0000_000D},
    '{1'b1, 8'h04, 32'h0000_0001, 32'hFFFF_FFFD, 32'h0000_0001},
    '{1'b1, 8'h08, 32'h0000_0001, 32'hFFFF_FFFD, 32'h0000_0001},
    '{1'b1, 8'h08, 32'h0000_0000, 32'hFFFF_FFFD, 32'h0000_0000},
    '{1'b1, 8'h20, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0000},
    '{1'b1, 8'h10, 32'hFFFF_FFFF, 32'h0000_007F, 32'h0000_0000},
    '{1'b1, 8'h14, 32'hFFFF_FFFF, 32'hFFFF_FFFF, `SCSS_SLOW_RC_OSC_HZ}};

  scss_top uut (.ref_clk, .rst_n, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .fast_crystal_osc, .fast_rc_osc,
    .slow_crystal_osc, .slow_rc_osc, .cpu_halt, .sysclk_out, .sub_clk_out, .fast_rc_run,
    .fast_rc_freq_sel, .fast_xtal_run, .slow_xtal_run, .slow_xtal_pins_osc);

  initial forever #4 ref_clk = ~ref_clk;

  // Oscillator stand-ins, half periods 1, 2, 8 and 6 cycles
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 4'h1;
    sx <= (sx == 4'h5) ? 4'h0 : sx + 4'h1;
    fast_rc_osc <= ~fast_rc_osc;
    if (cyc[0]) fast_crystal_osc <= ~fast_crystal_osc;
    if (cyc[2:0] == 3'h7) slow_rc_osc <= ~slow_rc_osc;
    if (sx == 4'h5) slow_crystal_osc <= ~slow_crystal_osc;
  end

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #(8 * 60000);
    n_errors++;
    end_sim();
  end

  task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic xf(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    q = hrdata;
  endtask

  // Falling-edge samples avoid racing the registered clock outputs
  task automatic meas(output int p, output int h);
    logic pv;
    p = 0;
    h = 0;
    pv = 1'b1;
    for (int i = 0; i < 1200; i++)
    begin
      @(negedge ref_clk);
      if (pv === 1'b0 && sysclk_out === 1'b1)
      begin
        if (p > 0) break;
        p = 1;
        h = 1;
      end
      else if (p > 0)
      begin
        p++;
        h += (sysclk_out === 1'b1);
      end
      pv = sysclk_out;
    end
  endtask

  task automatic cnt(int n, output int s, output int u);
    s = 0;
    u = 0;
    repeat (n)
    begin
      @(negedge ref_clk);
      s += (sysclk_out !== 1'b0);
      u += (sub_clk_out !== 1'b0);
    end
  endtask

  initial
  begin
    int p, h, s, u, hf;
    logic [31:0] q;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk({fast_rc_run, fast_rc_freq_sel, fast_xtal_run, slow_xtal_run, slow_xtal_pins_osc,
      hresp, hreadyout}, 32'h0000_0081, "reset outputs");
    $display("test reset done");
    foreach (rows[i])
    begin
      if (rows[i].w) xf(1'b1, rows[i].a, rows[i].d, q);
      xf(1'b0, rows[i].a, 32'h0000_0000, q);
      chk(q & rows[i].m, rows[i].e, "register row");
    end
    $display("test registers done");
    for (int k = 0; k < 3; k++)
    begin
      xf(1'b1, 8'h04, {28'h000_0000, k[1:0], 2'h1}, q);
      repeat (2) @(negedge ref_clk);
      chk(32'(fast_rc_freq_sel), k, "rc frequency select");
    end
    $display("test rc frequency done");
    for (int sr = 0; sr < 2; sr++)
      for (int n = 0; n < 7; n++)
      begin
        hf = sr + 1;
        xf(1'b1, 8'h00, {24'h00_0000, n[2:0], 1'b0, sr[0], 3'h0}, q);
        meas(p, h);
        meas(p, h);
        chk(p, (2 * hf) << n, "divided period");
        chk(h, hf << n, "divided high time");
      end
    $display("test divider done");
    xf(1'b1, 8'h00, 32'h0000_00E0, q);
    meas(p, h);
    meas(p, h);
    chk(p, 16, "slow rc period");
    xf(1'b1, 8'h04, 32'h0000_0000, q);
    repeat (4) @(negedge ref_clk);
    chk({fast_rc_run, fast_xtal_run}, 0, "fast osc stop on sub clock");
    xf(1'b1, 8'h04, 32'h0000_0001, q);
    repeat (4) @(negedge ref_clk);
    chk(fast_rc_run, 1, "fast osc keeps running");
    $display("test sub rc done");
    xf(1'b1, 8'h00, 32'h0000_0000, q);
    @(posedge ref_clk);
    cpu_halt <= 1'b1;
    // Sub gate closes only on a low phase, so wait out a full slow RC period
    repeat (20) @(negedge ref_clk);
    cnt(40, s, u);
    chk(s + u + int'(fast_rc_run), 0, "clocks run in sleep");
    xf(1'b1, 8'h00, 32'h0000_0001, q);
    cnt(40, s, u);
    chk({s == 0, u == 0}, 2, "idle sub clock");
    @(posedge ref_clk);
    cpu_halt <= 1'b0;
    meas(p, h);
    meas(p, h);
    chk(p, 2, "wake period");
    $display("test halt done");
    xf(1'b1, 8'h0C, 32'h0000_0001, q);
    repeat (3) @(negedge ref_clk);
    chk({slow_xtal_run, slow_xtal_pins_osc}, 0, "crystal without pins");
    xf(1'b1, 8'h0C, 32'h0000_0005, q);
    repeat (3) @(negedge ref_clk);
    chk({slow_xtal_run, slow_xtal_pins_osc}, 3, "crystal enable");
    xf(1'b1, 8'h00, 32'h0000_00E4, q);
    repeat (4) @(negedge ref_clk);
    cnt(60, s, u);
    chk(s, 0, "unready crystal clocks");
    xf(1'b0, 8'h0C, 32'h0000_0000, q);
    chk(q[1], 0, "crystal ready too soon");
    for (int i = 0; i < 300 && q[1] !== 1'b1; i++)
    begin
      repeat (50) @(negedge ref_clk);
      xf(1'b0, 8'h0C, 32'h0000_0000, q);
    end
    chk(q[1], 1, "crystal never ready");
    meas(p, h);
    meas(p, h);
    chk(p, 12, "slow crystal period");
    xf(1'b0, 8'h14, 32'h0000_0000, q);
    chk(q, `SCSS_LXT_HZ, "sub frequency");
    xf(1'b0, 8'h10, 32'h0000_0000, q);
    chk(q[4:0], 5'h1D, "active selection");
    $display("test slow crystal done");
    @(posedge ref_clk);
    clk_en <= 1'b0;
    @(negedge ref_clk);
    hf = sysclk_out;
    cnt(30, s, u);
    chk(s, 30 * hf, "clock enable freeze");
    $display("test clock enable done");
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({sysclk_out, sub_clk_out, slow_xtal_run, slow_xtal_pins_osc}, 0, "mid-run reset");
    @(posedge ref_clk);
    rst_n <= 1'b1;
    xf(1'b0, 8'h10, 32'h0000_0000, q);
    chk(q[6:0], 0, "selection after reset");
    $display("test mid-run reset done");
    end_sim();
  end
endmodule

`default_nettype wire
